// *** common/isrp_pkg.sv ***
package isrp_pkg;

  // ==========================================================
  // register indices
  localparam logic [7:0] IDX_SYNTH = 8'h03;
  localparam logic [7:0] IDX_RSSI = 8'h06;
  localparam logic [7:0] IDX_RADIO = 8'h07;
  localparam logic [7:0] IDX_AMP = 8'h09;
  localparam logic [7:0] IDX_OSC = 8'h0A;
  localparam logic [7:0] IDX_METER = 8'h0B;
  localparam logic [7:0] IDX_CAL = 8'h17;
  localparam logic [7:0] IDX_TRIM = 8'h1B;
  localparam logic [7:0] IDX_REV = 8'h1D;
  localparam logic [7:0] IDX_IDLO = 8'h1E;
  localparam logic [7:0] IDX_FIFO = 8'h32;

  // ==========================================================
  // slave address parts
  localparam logic ADDR_TOP = 1'b0;
  localparam logic [3:0] ADDR_LOW = 4'h8;

  // ==========================================================
  // field positions
  localparam int LOCK_BIT = 12;
  localparam int RSSI_LSB = 10;
  localparam int TXGO_BIT = 8;
  localparam int RXGO_BIT = 7;
  localparam int CHAN_LSB = 0;
  localparam int AMPCUR_LSB = 12;
  localparam int AMPGN_LSB = 7;
  localparam int OSCEN_BIT = 0;
  localparam int METER_BIT = 8;
  localparam int CAL_BIT = 2;
  localparam int TRIM_LSB = 0;
  localparam int RFREV_LSB = 4;
  localparam int DIGREV_LSB = 0;

  // ==========================================================
  // writable bit masks and reset values
  localparam logic [15:0] RADIO_MASK = 16'h01FF;
  localparam logic [15:0] AMP_MASK = 16'hF780;
  localparam logic [15:0] OSC_MASK = 16'h0001;
  localparam logic [15:0] METER_MASK = 16'h0100;
  localparam logic [15:0] CAL_MASK = 16'h0004;
  localparam logic [15:0] TRIM_MASK = 16'h003F;
  localparam logic [15:0] REG_RST = 16'h0000;

  // ==========================================================
  // channel to frequency
  localparam logic [11:0] FREQ_BASE_MHZ = 12'h962;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_INDEX, ST_IACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_WAIT
  } isrp_state_e;

  typedef struct packed {
    logic [6:0] channel_number;
    logic [11:0] freq_mhz;
    logic [3:0] amp_current_ctrl;
    logic [3:0] amp_gain;
    logic osc_gain_enable;
    logic signal_meter_powerdown;
    logic vco_cal_each_enable;
    logic [5:0] osc_trim;
  } isrp_cfg_s;

endpackage

// *** verilog/isrp_sync.sv ***
`timescale 1ns/100ps
module isrp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

// *** verilog/isrp_buf2.sv ***
`timescale 1ns/100ps
module isrp_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // ==========================================================
  // storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  // ==========================================================
  // pointers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// *** verilog/isrp_slave.sv ***
// Functional notes
// RL1 - write: start, address+W, index byte, data bytes, each acked, stop; code nacks fifo data bytes while the write buffer is full
// RL2 - read: index write, repeated start, address+R, bytes until stop
// RL3 - read without index continues from the previously selected location
// RL4 - works at 100, 400 and 1000 kbps serial clock rates
// RL5 - no high-speed, stretch, 10-bit, general call, reset, ID; SCL not held
// RL6 - address 0,bond,strap,1000; direction bit 1 read, 0 write
// RL7 - synth status bit 12 shows synthesizer lock
// RL8 - signal-strength bits 15:10 show raw analog value, read only
// RL9 - setting bit 8 starts transmit, bit 7 starts receive
// RL10 - host never sets transmit-go and receive-go together
// RL11 - 7-bit channel; frequency MHz equals 2402 plus channel
// RL12 - amplifier current bits 15:12, gain bits 10:7
// RL13 - oscillator bit 0 enables crystal gain block
// RL14 - meter bit 8 powers down strength measurement
// RL15 - calibration bit 2 requests VCO calibration before each enable
// RL16 - trim bits 5:0 adjust crystal frequency
// RL17 - revision: RF bits 7:4, digital bits 2:0, read only
// RL18 - identity-low returns maker code low half, lsb always 1
// RL19 - registers reachable only over the two-wire port
// RL20 - host leaves undocumented registers at factory values
// RL21 - 16-bit words move MSB first; foreign addresses not acked
`timescale 1ns/100ps
module isrp_slave
  import isrp_pkg::*;
#(
  parameter logic [3:0] RF_REV = 4'h1,
  parameter logic [2:0] DIG_REV = 3'h1,
  // arbitrary neutral value
  parameter logic [15:0] MAKER_CODE_LOW = 16'h0001,
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic hw_rst_n_in,
  // two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // address straps
  input wire logic addr_bond_in,
  input wire logic addr_strap_in,
  // analog status
  input wire logic synth_lock_flag_in,
  input wire logic [5:0] signal_strength_raw_in,
  // radio control
  output isrp_pkg::isrp_cfg_s cfg_out,
  output logic tx_go_out,
  output logic rx_go_out,
  output logic vco_cal_req_out,
  // fifo write stream
  output logic fifo_wr_valid_out,
  input wire logic fifo_wr_ready_in,
  output logic [7:0] fifo_wr_data_out,
  // fifo read stream
  input wire logic fifo_rd_valid_in,
  output logic fifo_rd_ready_out,
  input wire logic [7:0] fifo_rd_data_in
);

  import isrp_pkg::*;

  // ==========================================================
  // synchronisers
  logic [4:0] pin_s;
  logic [6:0] ana_s;
  logic scl_s;
  logic sda_s;
  logic hw_rst_s;
  logic lock_s;
  logic [5:0] rssi_s;

  isrp_sync #(.W(5)) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    // bus lines inverted so a cleared synchroniser reads as idle bus
    .d_in({~scl_in, ~sda_in, ~hw_rst_n_in, addr_bond_in, addr_strap_in}),
    .q_out(pin_s)
  );

  isrp_sync #(.W(7)) u_ana_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({synth_lock_flag_in, signal_strength_raw_in}),
    .q_out(ana_s)
  );

  assign scl_s = ~pin_s[4];
  assign sda_s = ~pin_s[3];
  assign hw_rst_s = pin_s[2];
  assign lock_s = ana_s[6];
  assign rssi_s = ana_s[5:0];

  // ==========================================================
  // line edges and bus conditions
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ==========================================================
  // address straps caught after reset release
  logic [1:0] strap_wait_q;
  logic [1:0] strap_q;
  logic [6:0] dev_addr;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_wait_q <= 2'h0;
      strap_q <= 2'h0;
    end else if (strap_wait_q != 2'h3) begin
      // last capture at third edge, once the synchroniser holds the pins
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_q <= pin_s[1:0];
    end
  end

  // RL6 own address
  assign dev_addr = {ADDR_TOP, strap_q, ADDR_LOW};

  // ==========================================================
  // byte engine state
  isrp_state_e state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic drv_q;
  logic rw_q;
  logic [7:0] idx_q;
  logic half_q;
  logic [7:0] hi_q;
  logic ack_ok_q;
  logic rx_state;
  logic byte_done;
  logic byte_ack;
  logic rd_load;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;
  logic is_fifo;
  logic buf_in_ready;
  logic fifo_push;
  logic wr_commit;
  logic [15:0] wr_word;

  assign is_fifo = (idx_q == IDX_FIFO);
  assign rx_state = (state_q == ST_ADDR) | (state_q == ST_INDEX) |
                    (state_q == ST_WDATA);
  assign byte_done = rx_state & scl_fall & (cnt_q == 4'h8);

  // RL21 foreign address left unacked
  always_comb begin
    case (state_q)
      ST_ADDR: byte_ack = (sh_q[7:1] == dev_addr);
      ST_INDEX: byte_ack = 1'b1;
      ST_WDATA: byte_ack = ~is_fifo | buf_in_ready;
      default: byte_ack = 1'b0;
    endcase
  end

  assign rd_load = scl_fall & (((state_q == ST_AACK) & rw_q) |
                               ((state_q == ST_RACK) & ack_ok_q));
  assign fifo_push = byte_done & (state_q == ST_WDATA) & is_fifo &
                     buf_in_ready;
  assign wr_commit = byte_done & (state_q == ST_WDATA) & ~is_fifo & half_q;
  assign wr_word = {hi_q, sh_q};

  // RL5 only data line is driven, low only
  assign sda_out = 1'b0;
  assign sda_oe_out = drv_q;

  // ==========================================================
  // bit and byte sequencing
  // RL1 write sequence
  // RL2 read after repeated start
  // RL4 edges sampled at core rate
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      drv_q <= 1'b0;
      rw_q <= 1'b0;
      ack_ok_q <= 1'b0;
    end else if (hw_rst_s | stop_det) begin
      state_q <= ST_IDLE;
      drv_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      cnt_q <= 4'h0;
      drv_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            if (!byte_ack) begin
              state_q <= ST_WAIT;
            end else begin
              drv_q <= 1'b1;
              if (state_q == ST_ADDR) begin
                rw_q <= sh_q[0];
                state_q <= ST_AACK;
              end else if (state_q == ST_INDEX) begin
                state_q <= ST_IACK;
              end else begin
                state_q <= ST_WACK;
              end
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            // RL3 read without index reuses idx_q
            if (rw_q) begin
              sh_q <= rd_byte;
              drv_q <= ~rd_byte[7];
              cnt_q <= 4'h0;
              state_q <= ST_RDATA;
            end else begin
              drv_q <= 1'b0;
              state_q <= ST_INDEX;
            end
          end
        end
        ST_IACK, ST_WACK: begin
          if (scl_fall) begin
            drv_q <= 1'b0;
            state_q <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              drv_q <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              drv_q <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_ok_q <= ~sda_s;
          end else if (scl_fall) begin
            if (ack_ok_q) begin
              sh_q <= rd_byte;
              drv_q <= ~rd_byte[7];
              cnt_q <= 4'h0;
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_IDLE, ST_WAIT: begin
          drv_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          drv_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // index and byte pairing
  // RL21 high byte first, then low byte
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idx_q <= 8'h00;
      half_q <= 1'b0;
      hi_q <= 8'h00;
    end else if (hw_rst_s) begin
      idx_q <= 8'h00;
      half_q <= 1'b0;
    end else if (byte_done & byte_ack & (state_q == ST_INDEX)) begin
      idx_q <= sh_q;
      half_q <= 1'b0;
    end else if (byte_done & (state_q == ST_WDATA) & ~is_fifo) begin
      hi_q <= sh_q;
      half_q <= ~half_q;
    end else if (rd_load & ~is_fifo) begin
      half_q <= ~half_q;
    end
  end

  // ==========================================================
  // writable registers
  logic [15:0] radio_q;
  logic [15:0] amp_q;
  logic [15:0] osc_q;
  logic [15:0] meter_q;
  logic [15:0] cal_q;
  logic [15:0] trim_q;

  // RL19 written only through the serial port
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      radio_q <= REG_RST;
      amp_q <= REG_RST;
      osc_q <= REG_RST;
      meter_q <= REG_RST;
      cal_q <= REG_RST;
      trim_q <= REG_RST;
    end else if (hw_rst_s) begin
      radio_q <= REG_RST;
      amp_q <= REG_RST;
      osc_q <= REG_RST;
      meter_q <= REG_RST;
      cal_q <= REG_RST;
      trim_q <= REG_RST;
    end else if (wr_commit) begin
      // RL20 other indices ignored
      case (idx_q)
        IDX_RADIO: radio_q <= wr_word & RADIO_MASK;
        IDX_AMP: amp_q <= wr_word & AMP_MASK;
        IDX_OSC: osc_q <= wr_word & OSC_MASK;
        IDX_METER: meter_q <= wr_word & METER_MASK;
        IDX_CAL: cal_q <= wr_word & CAL_MASK;
        IDX_TRIM: trim_q <= wr_word & TRIM_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // start pulses
  logic tx_set;
  logic rx_set;

  // RL10 both set together: neither starts
  assign tx_set = wr_commit & (idx_q == IDX_RADIO) &
                  wr_word[TXGO_BIT] & ~wr_word[RXGO_BIT] &
                  ~radio_q[TXGO_BIT];
  assign rx_set = wr_commit & (idx_q == IDX_RADIO) &
                  wr_word[RXGO_BIT] & ~wr_word[TXGO_BIT] &
                  ~radio_q[RXGO_BIT];

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_go_out <= 1'b0;
      rx_go_out <= 1'b0;
      vco_cal_req_out <= 1'b0;
    end else begin
      // RL9 start transmit or receive
      tx_go_out <= tx_set;
      rx_go_out <= rx_set;
      // RL15 calibrate before each enable
      vco_cal_req_out <= (tx_set | rx_set) & cal_q[CAL_BIT];
    end
  end

  // ==========================================================
  // configuration outputs
  logic [11:0] freq_q;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      freq_q <= FREQ_BASE_MHZ;
    end else begin
      // RL11 channel to frequency
      freq_q <= FREQ_BASE_MHZ + {5'h00, radio_q[CHAN_LSB +: 7]};
    end
  end

  always_comb begin
    cfg_out.channel_number = radio_q[CHAN_LSB +: 7];
    cfg_out.freq_mhz = freq_q;
    // RL12 amplifier fields
    cfg_out.amp_current_ctrl = amp_q[AMPCUR_LSB +: 4];
    cfg_out.amp_gain = amp_q[AMPGN_LSB +: 4];
    // RL13 crystal gain enable
    cfg_out.osc_gain_enable = osc_q[OSCEN_BIT];
    // RL14 strength meter power down
    cfg_out.signal_meter_powerdown = meter_q[METER_BIT];
    cfg_out.vco_cal_each_enable = cal_q[CAL_BIT];
    // RL16 crystal trim
    cfg_out.osc_trim = trim_q[TRIM_LSB +: 6];
  end

  // ==========================================================
  // read-back
  always_comb begin
    rd_word = 16'h0000;
    case (idx_q)
      // RL7 lock status
      IDX_SYNTH: rd_word[LOCK_BIT] = lock_s;
      // RL8 raw strength
      IDX_RSSI: rd_word[RSSI_LSB +: 6] = rssi_s;
      IDX_RADIO: rd_word = radio_q;
      IDX_AMP: rd_word = amp_q;
      IDX_OSC: rd_word = osc_q;
      IDX_METER: rd_word = meter_q;
      IDX_CAL: rd_word = cal_q;
      IDX_TRIM: rd_word = trim_q;
      // RL17 revision fields
      IDX_REV: begin
        rd_word[RFREV_LSB +: 4] = RF_REV;
        rd_word[DIGREV_LSB +: 3] = DIG_REV;
      end
      // RL18 lsb forced to one
      IDX_IDLO: rd_word = MAKER_CODE_LOW | 16'h0001;
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    if (is_fifo) begin
      rd_byte = fifo_rd_valid_in ? fifo_rd_data_in : 8'h00;
    end else begin
      rd_byte = half_q ? rd_word[7:0] : rd_word[15:8];
    end
  end

  assign fifo_rd_ready_out = rd_load & is_fifo & fifo_rd_valid_in;

  // ==========================================================
  // fifo write path
  isrp_buf2 #(.W(8), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(buf_in_ready),
    .in_data_in(sh_q),
    .out_valid_out(fifo_wr_valid_out),
    .out_ready_in(fifo_wr_ready_in),
    .out_data_out(fifo_wr_data_out)
  );

endmodule

// *** tb/isrp_monitor.sv ***
`timescale 1ns/100ps
module isrp_monitor
  import isrp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_oe_out,
  // radio control
  input wire isrp_pkg::isrp_cfg_s cfg_out,
  input wire logic tx_go_out,
  input wire logic rx_go_out,
  input wire logic vco_cal_req_out,
  // fifo streams
  input wire logic fifo_wr_valid_out,
  input wire logic fifo_wr_ready_in,
  input wire logic [7:0] fifo_wr_data_out,
  input wire logic fifo_rd_ready_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // ==========================================================
  // sequences
  sequence s_go;
    tx_go_out || rx_go_out;
  endsequence
  sequence s_stall;
    fifo_wr_valid_out && !fifo_wr_ready_in;
  endsequence

  // ==========================================================
  // properties
  property p_oe_scl_low;
    !$stable(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda moved while scl high");
  property p_oe_hold;
    $rose(sda_oe_out) |=> sda_oe_out [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("sda drive too short");
  property p_go_pulse;
    s_go |=> !tx_go_out && !rx_go_out;
  endproperty
  a_go_pulse: assert property (p_go_pulse)
    else $error("go pulse too long");
  property p_cal_pair;
    vco_cal_req_out |-> s_go ##0 cfg_out.vco_cal_each_enable;
  endproperty
  a_cal_pair: assert property (p_cal_pair)
    else $error("calibration without go or enable");
  property p_cal_need;
    s_go ##0 cfg_out.vco_cal_each_enable |-> vco_cal_req_out;
  endproperty
  a_cal_need: assert property (p_cal_need)
    else $error("calibration missing");
  property p_freq;
    $stable(cfg_out.channel_number) |->
      cfg_out.freq_mhz == FREQ_BASE_MHZ + 12'(cfg_out.channel_number);
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency not base plus channel");
  property p_wr_hold;
    s_stall |=> fifo_wr_valid_out && $stable(fifo_wr_data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("stalled byte changed");
  property p_rd_pulse;
    fifo_rd_ready_out |=> !fifo_rd_ready_out;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read take too long");
endmodule

bind isrp_slave isrp_monitor i_mon (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
  .cfg_out(cfg_out), .tx_go_out(tx_go_out), .rx_go_out(rx_go_out),
  .vco_cal_req_out(vco_cal_req_out), .fifo_wr_valid_out(fifo_wr_valid_out),
  .fifo_wr_ready_in(fifo_wr_ready_in), .fifo_wr_data_out(fifo_wr_data_out),
  .fifo_rd_ready_out(fifo_rd_ready_out));

// *** tb/isrp_host.sv ***
`timescale 1ns/100ps
module isrp_host (
  // clock
  input wire logic clk_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // ==========================================================
  // idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // quarter of the serial clock period
  task automatic qtr();
    repeat (10) @(posedge clk_in);
  endtask

  task automatic start();
    sda_oe_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_oe_out <= 1'b1;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask

  task automatic stop();
    sda_oe_out <= 1'b1;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_oe_out <= 1'b0;
    qtr();
  endtask

  // data moves only while clock is low
  task automatic xbit(input logic b, output logic r);
    sda_oe_out <= !b;
    qtr();
    scl_out <= 1'b1;
    qtr();
    r = sda_in;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask

  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(a, ar);
  endtask
endmodule

// *** tb/isrp_slave_test.sv ***
`timescale 1ns/100ps
module isrp_slave_test;
  import isrp_pkg::*;
  localparam logic [3:0] RFR = 4'h3;
  localparam logic [2:0] DGR = 3'h5;
  // arbitrary value, lsb set
  localparam logic [15:0] MKL = 16'h0C35;
  localparam logic [7:0] AW = {ADDR_TOP, 2'b10, ADDR_LOW, 1'b0};
  localparam logic [7:0] AR = {ADDR_TOP, 2'b10, ADDR_LOW, 1'b1};
  localparam int LIMIT = 70000;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hw_rst_n_in = 1'b1;
  logic lock = 1'b0;
  logic [5:0] rssi = 6'h00;
  logic wr_rdy = 1'b0;
  logic [7:0] rd_data = 8'hA5;
  logic scl, host_oe, sda_o, sda_oe, tx_go, rx_go, cal, wr_vld, rd_rdy, ak;
  logic [7:0] wr_data, rb;
  logic [15:0] v;
  isrp_cfg_s cfg, e;
  logic [7:0] wq[$];
  logic [7:0] rw_idx [5] = '{IDX_AMP, IDX_OSC, IDX_METER, IDX_CAL, IDX_TRIM};
  logic [15:0] rw_msk [5] = '{AMP_MASK, OSC_MASK, METER_MASK, CAL_MASK,
                              TRIM_MASK};
  logic [7:0] bad [4] = '{8'h10, 8'h70, 8'h40, 8'hD0};
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_tx = 0;
  int n_rx = 0;
  int n_cal = 0;
  wire sda;

  // ==========================================================
  // clock, wire level, design and host
  always #2 clk_in = ~clk_in;
  assign sda = !(host_oe || (sda_oe && !sda_o));
  isrp_host i_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(host_oe));
  isrp_slave #(.RF_REV(RFR), .DIG_REV(DGR), .MAKER_CODE_LOW(MKL)) i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hw_rst_n_in(hw_rst_n_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .addr_bond_in(1'b1), .addr_strap_in(1'b0),
    .synth_lock_flag_in(lock), .signal_strength_raw_in(rssi),
    .cfg_out(cfg), .tx_go_out(tx_go), .rx_go_out(rx_go),
    .vco_cal_req_out(cal), .fifo_wr_valid_out(wr_vld),
    .fifo_wr_ready_in(wr_rdy), .fifo_wr_data_out(wr_data),
    .fifo_rd_valid_in(1'b1), .fifo_rd_ready_out(rd_rdy),
    .fifo_rd_data_in(rd_data));

  // pulse counts, write capture, read source, timeout
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    n_tx <= n_tx + int'(tx_go);
    n_rx <= n_rx + int'(rx_go);
    n_cal <= n_cal + int'(cal);
    if (wr_vld && wr_rdy) wq.push_back(wr_data);
    if (rd_rdy) rd_data <= rd_data + 8'h11;
    if (cycles == LIMIT) begin
      fails++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [35:0] x, got);
    total_checks++;
    if (got !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", what, x, got);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic acked);
    i_host.xbyte(d, 1'b1, rb, ak);
    chk("ack", 36'(!acked), 36'(ak));
  endtask
  task automatic recv(input logic last, input logic [7:0] x);
    i_host.xbyte(8'hFF, last, rb, ak);
    chk("byte", 36'(x), 36'(rb));
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
    i_host.start();
    send(AW, 1'b1);
    send(idx, 1'b1);
    send(d[15:8], 1'b1);
    send(d[7:0], 1'b1);
    i_host.stop();
  endtask
  task automatic cr(input logic [7:0] idx, input logic [15:0] x);
    i_host.start();
    send(AW, 1'b1);
    send(idx, 1'b1);
    i_host.start();
    send(AR, 1'b1);
    recv(1'b0, x[15:8]);
    recv(1'b1, x[7:0]);
    i_host.stop();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    e = '0;
    e.freq_mhz = FREQ_BASE_MHZ;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk("cfg", e, cfg);
    cr(IDX_TRIM, REG_RST);
    $display("reset test done");
    wreg(IDX_RADIO, 16'h0105);
    e.channel_number = 7'h05;
    e.freq_mhz = FREQ_BASE_MHZ + 12'h005;
    chk("cfg", e, cfg);
    chk("tx", 36'd1, 36'(n_tx));
    wreg(IDX_RADIO, 16'h0085);
    chk("rx", 36'd1, 36'(n_rx));
    cr(IDX_RADIO, 16'h0085);
    chk("cal", 36'd0, 36'(n_cal));
    wreg(IDX_CAL, CAL_MASK);
    wreg(IDX_RADIO, 16'h0105);
    chk("tx", 36'd2, 36'(n_tx));
    chk("cal", 36'd1, 36'(n_cal));
    $display("go test done");
    for (int i = 0; i < 5; i++) begin
      wreg(rw_idx[i], rw_msk[i]);
      cr(rw_idx[i], rw_msk[i]);
    end
    e.amp_current_ctrl = AMP_MASK[15:12];
    e.amp_gain = AMP_MASK[10:7];
    e.osc_gain_enable = 1'b1;
    e.signal_meter_powerdown = 1'b1;
    e.vco_cal_each_enable = 1'b1;
    e.osc_trim = TRIM_MASK[5:0];
    chk("cfg", e, cfg);
    wreg(IDX_REV, 16'h0000);
    cr(IDX_REV, {8'h00, RFR, 1'b0, DGR});
    cr(IDX_IDLO, MKL);
    cr(8'h40, 16'h0000);
    lock <= 1'b1;
    rssi <= 6'h2D;
    cr(IDX_SYNTH, 16'h1 << LOCK_BIT);
    lock <= 1'b0;
    cr(IDX_SYNTH, 16'h0000);
    cr(IDX_RSSI, {6'h2D, 10'h000});
    foreach (bad[i]) begin
      i_host.start();
      send(bad[i], 1'b0);
      i_host.stop();
    end
    $display("register test done");
    i_host.start();
    send(AW, 1'b1);
    send(IDX_FIFO, 1'b1);
    send(8'h3C, 1'b1);
    send(8'hC3, 1'b1);
    send(8'h5A, 1'b0);
    i_host.stop();
    wr_rdy <= 1'b1;
    for (int k = 0; k < 20 && wq.size() < 2; k++) begin
      @(posedge clk_in);
    end
    repeat (2) @(posedge clk_in);
    chk("wq", 36'h2, 36'(wq.size()));
    chk("wq0", 36'h3C, 36'(wq[0]));
    chk("wq1", 36'hC3, 36'(wq[1]));
    chk("wr_vld", 36'h0, 36'(wr_vld));
    i_host.start();
    send(AW, 1'b1);
    send(IDX_FIFO, 1'b1);
    i_host.start();
    send(AR, 1'b1);
    recv(1'b0, 8'hA5);
    recv(1'b1, 8'hB6);
    i_host.stop();
    i_host.start();
    send(AR, 1'b1);
    recv(1'b1, 8'hC7);
    i_host.stop();
    $display("fifo test done");
    hw_rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    hw_rst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    e = '0;
    e.freq_mhz = FREQ_BASE_MHZ;
    chk("cfg", e, cfg);
    $display("pin reset test done");
    tally_and_finish();
  end
endmodule
